// *** rtl/dpg_pkg.sv ***
package dpg_pkg;

  // ----------------------------------------
  // register map, full 16-bit addresses
  // ----------------------------------------
  localparam logic [15:0] UPPER_DIR_ADDR  = 16'hffc4;
  localparam logic [15:0] LOWER_DIR_ADDR  = 16'hffc5;
  localparam logic [15:0] UPPER_DATA_ADDR = 16'hffc6;
  localparam logic [15:0] LOWER_DATA_ADDR = 16'hffc7;
  localparam logic [15:0] LOWER_PU_ADDR   = 16'hffda;

  localparam logic [7:0]  REG_RESET       = 8'h00;
  localparam logic [7:0]  WO_READ_VALUE   = 8'hff;
  localparam logic [7:0]  UNMAPPED_VALUE  = 8'h00;
  localparam logic [7:0]  ALL_BYTE_AREAS  = 8'hff;

  // ----------------------------------------
  // operating modes
  // ----------------------------------------
  localparam logic [2:0]  MODE_EXP_FIRST  = 3'h1;
  localparam logic [2:0]  MODE_EXP_LAST   = 3'h6;
  localparam logic [2:0]  MODE_SINGLE     = 3'h7;

  typedef struct packed {
    logic [7:0] dir_u;
    logic [7:0] dir_l;
    logic [7:0] dat_u;
    logic [7:0] dat_l;
    logic [7:0] pu_en;
    logic [7:0] sy1_u;
    logic [7:0] sy2_u;
    logic [7:0] sy1_l;
    logic [7:0] sy2_l;
    logic [7:0] rdata;
    logic [7:0] pin_u;
    logic [7:0] oe_u;
    logic [7:0] pin_l;
    logic [7:0] oe_l;
    logic [7:0] pull;
    logic [15:0] bus_rd;
  } dpg_state_type;

endpackage

// *** rtl/dpg_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module dpg_top
  import dpg_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_hw_standby,
  input  wire logic        i_sw_standby,
  input  wire logic [2:0]  i_mode,
  input  wire logic [7:0]  i_bus_area_width_control,
  input  wire logic        i_bus_drive,
  input  wire logic [15:0] i_bus_wdata,
  output logic      [15:0] o_bus_rdata,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic [7:0]  i_upper_pin,
  output logic      [7:0]  o_upper_pin,
  output logic      [7:0]  o_upper_pin_oe,
  input  wire logic [7:0]  i_lower_pin,
  output logic      [7:0]  o_lower_pin,
  output logic      [7:0]  o_lower_pin_oe,
  output logic      [7:0]  o_lower_pullup
);

  dpg_state_type s_q;
  dpg_state_type s_d;
  logic          expanded;
  logic          wide_bus;
  logic [7:0]    rd_u;
  logic [7:0]    rd_l;

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  // mode 0 is not a legal strap; it falls back to port use, the safe choice
  assign expanded = (i_mode >= MODE_EXP_FIRST) && (i_mode <= MODE_EXP_LAST);
  // single-chip never looks at the width control
  assign wide_bus = expanded && (i_bus_area_width_control != ALL_BYTE_AREAS);

  // port reads mix latched bits for outputs with pin levels for inputs
  assign rd_u = (s_q.dat_u & s_q.dir_u) | (s_q.sy2_u & ~s_q.dir_u);
  assign rd_l = (s_q.dat_l & s_q.dir_l) | (s_q.sy2_l & ~s_q.dir_l);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.sy1_u = i_upper_pin;
    s_d.sy2_u = s_q.sy1_u;
    s_d.sy1_l = i_lower_pin;
    s_d.sy2_l = s_q.sy1_l;

    // register writes land even while the pins belong to the bus
    if (i_wr) begin
      case (i_addr)
        UPPER_DIR_ADDR: begin
          s_d.dir_u = i_wdata;
        end
        LOWER_DIR_ADDR: begin
          s_d.dir_l = i_wdata;
        end
        UPPER_DATA_ADDR: begin
          s_d.dat_u = i_wdata;
        end
        LOWER_DATA_ADDR: begin
          s_d.dat_l = i_wdata;
        end
        LOWER_PU_ADDR: begin
          s_d.pu_en = i_wdata;
        end
        default: begin
          s_d.rdata = s_q.rdata;
        end
      endcase
    end

    // read data stands for one cycle only
    s_d.rdata = UNMAPPED_VALUE;
    if (i_rd) begin
      case (i_addr)
        UPPER_DIR_ADDR: begin
          s_d.rdata = WO_READ_VALUE;
        end
        LOWER_DIR_ADDR: begin
          s_d.rdata = WO_READ_VALUE;
        end
        UPPER_DATA_ADDR: begin
          s_d.rdata = rd_u;
        end
        LOWER_DATA_ADDR: begin
          s_d.rdata = rd_l;
        end
        LOWER_PU_ADDR: begin
          s_d.rdata = s_q.pu_en;
        end
        default: begin
          s_d.rdata = UNMAPPED_VALUE;
        end
      endcase
    end

    // upper port pins
    if (expanded) begin
      s_d.oe_u  = {8{i_bus_drive}};
      s_d.pin_u = i_bus_wdata[15:8];
    end else begin
      // software standby changes nothing here, so outputs stay driven
      s_d.oe_u  = s_q.dir_u;
      s_d.pin_u = s_q.dat_u;
    end

    // lower port pins
    if (wide_bus) begin
      s_d.oe_l  = {8{i_bus_drive}};
      s_d.pin_l = i_bus_wdata[7:0];
      s_d.pull  = REG_RESET;
    end else begin
      s_d.oe_l  = s_q.dir_l;
      s_d.pin_l = s_q.dat_l;
      s_d.pull  = s_q.pu_en & ~s_q.dir_l;
    end

    s_d.bus_rd = {s_q.sy2_u, s_q.sy2_l};

    // hardware standby clears the port registers, output enables and pull-ups; software standby keeps all
    if (i_hw_standby) begin
      s_d.dir_u = REG_RESET;
      s_d.dir_l = REG_RESET;
      s_d.dat_u = REG_RESET;
      s_d.dat_l = REG_RESET;
      s_d.pu_en = REG_RESET;
      s_d.oe_u  = REG_RESET;
      s_d.oe_l  = REG_RESET;
      s_d.pull  = REG_RESET;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata        = s_q.rdata;
  assign o_bus_rdata    = s_q.bus_rd;
  assign o_upper_pin    = s_q.pin_u;
  assign o_upper_pin_oe = s_q.oe_u;
  assign o_lower_pin    = s_q.pin_l;
  assign o_lower_pin_oe = s_q.oe_l;
  assign o_lower_pullup = s_q.pull;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  logic unused_ok;
  assign unused_ok = i_sw_standby;

  sequence s_single_hold;
    (i_mode == MODE_SINGLE && !i_hw_standby) [*2];
  endsequence

  sequence s_upper_dir_wr;
    i_wr && i_addr == UPPER_DIR_ADDR;
  endsequence

  upper_dir_ro_a: assert property (
    i_rd && i_addr == UPPER_DIR_ADDR |=> o_rdata == 8'hff
  ) else $error("upper direction read not all ones");

  lower_dir_ro_a: assert property (
    i_rd && i_addr == LOWER_DIR_ADDR |=> o_rdata == 8'hff
  ) else $error("lower direction read not all ones");

  upper_dir_pins_a: assert property (
    s_upper_dir_wr ##0 s_single_hold |-> ##1 o_upper_pin_oe == $past(i_wdata, 2)
  ) else $error("upper direction write did not reach the pins");

  hw_standby_clr_a: assert property (
    i_hw_standby ##1 i_hw_standby |-> ##1 o_upper_pin_oe == 8'h00 && o_lower_pin_oe == 8'h00
  ) else $error("hardware standby did not release pins");

  upper_bus_own_a: assert property (
    expanded && !i_bus_drive && !i_hw_standby |=> o_upper_pin_oe == 8'h00
  ) else $error("upper direction leaked into bus mode");

  lower_bus_own_a: assert property (
    wide_bus && i_bus_drive && !i_hw_standby |=> o_lower_pin_oe == 8'hff
      && o_lower_pin == $past(i_bus_wdata[7:0])
  ) else $error("lower port not following the bus");

  pullup_input_a: assert property (
    (o_lower_pullup & o_lower_pin_oe) == 8'h00
  ) else $error("pull-up on a driven pin");

  data_kept_a: assert property (
    i_wr && i_addr == UPPER_DATA_ADDR && !i_hw_standby && s_q.dir_u == 8'hff
      ##1 i_rd && i_addr == UPPER_DATA_ADDR && !i_hw_standby
      |=> o_rdata == $past(i_wdata, 2)
  ) else $error("upper data write lost");

  // ----------------------------------------
  // pin ownership and register checks
  // ----------------------------------------
  // every output is a flop, so most checks compare one edge apart
  // hardware standby is excluded where it overrides the normal path
  sequence s_lower_dir_wr;
    i_wr && i_addr == LOWER_DIR_ADDR;
  endsequence

  sequence s_lower_gpio_hold;
    (!wide_bus && !i_hw_standby) [*2];
  endsequence

  lower_dir_pins_a: assert property (
    s_lower_dir_wr ##0 s_lower_gpio_hold |-> ##1 o_lower_pin_oe == $past(i_wdata, 2)
  ) else $error("lower direction write did not reach the pins");

  upper_bus_drive_a: assert property (
    expanded && i_bus_drive && !i_hw_standby |=> o_upper_pin_oe == 8'hff
  ) else $error("upper port not driven by the bus");

  upper_bus_data_a: assert property (
    expanded |=> o_upper_pin == $past(i_bus_wdata[15:8])
  ) else $error("upper port not carrying the upper bus byte");

  upper_gpio_out_a: assert property (
    !expanded |=> o_upper_pin == $past(s_q.dat_u)
  ) else $error("upper data register not on the pins");

  upper_gpio_dir_a: assert property (
    !expanded && !i_hw_standby |=> o_upper_pin_oe == $past(s_q.dir_u)
  ) else $error("upper direction register not steering the pins");

  lower_gpio_dir_a: assert property (
    !wide_bus && !i_hw_standby |=> o_lower_pin_oe == $past(s_q.dir_l)
      && o_lower_pin == $past(s_q.dat_l)
  ) else $error("lower port not following its registers");

  lower_bus_data_a: assert property (
    wide_bus |=> o_lower_pin == $past(i_bus_wdata[7:0])
  ) else $error("lower port not carrying the lower bus byte");

  byte_bus_free_a: assert property (
    expanded && i_bus_area_width_control == ALL_BYTE_AREAS && !i_hw_standby
      |=> o_lower_pin_oe == $past(s_q.dir_l)
  ) else $error("byte-wide bus did not free the lower port");

  pullup_bus_off_a: assert property (
    wide_bus || i_hw_standby |=> o_lower_pullup == 8'h00
  ) else $error("pull-up on while the lower port is bus");

  pullup_gpio_a: assert property (
    !wide_bus && !i_hw_standby |=> o_lower_pullup == $past(s_q.pu_en & ~s_q.dir_l)
  ) else $error("pull-up not following its enable register");

  upper_data_rd_a: assert property (
    i_rd && i_addr == UPPER_DATA_ADDR
      |=> (o_rdata & $past(s_q.dir_u)) == $past(s_q.dat_u & s_q.dir_u)
      && (o_rdata & ~$past(s_q.dir_u)) == $past(s_q.sy2_u & ~s_q.dir_u)
  ) else $error("upper data read mixed the wrong sources");

  lower_data_rd_a: assert property (
    i_rd && i_addr == LOWER_DATA_ADDR
      |=> (o_rdata & $past(s_q.dir_l)) == $past(s_q.dat_l & s_q.dir_l)
      && (o_rdata & ~$past(s_q.dir_l)) == $past(s_q.sy2_l & ~s_q.dir_l)
  ) else $error("lower data read mixed the wrong sources");

  rdata_idle_a: assert property (
    !i_rd |=> o_rdata == 8'h00
  ) else $error("read data stood beyond its cycle");

  hw_standby_regs_a: assert property (
    i_hw_standby |=> s_q.dat_u == 8'h00 && s_q.dat_l == 8'h00 && s_q.pu_en == 8'h00
      && s_q.dir_u == 8'h00 && s_q.dir_l == 8'h00
  ) else $error("hardware standby left a register set");

  sw_standby_keep_a: assert property (
    i_sw_standby && !i_wr && !i_hw_standby |=> s_q.dir_u == $past(s_q.dir_u)
      && s_q.dat_u == $past(s_q.dat_u) && s_q.dir_l == $past(s_q.dir_l)
      && s_q.dat_l == $past(s_q.dat_l) && s_q.pu_en == $past(s_q.pu_en)
  ) else $error("software standby lost register contents");

  lower_data_wr_a: assert property (
    i_wr && i_addr == LOWER_DATA_ADDR && !i_hw_standby |=> s_q.dat_l == $past(i_wdata)
  ) else $error("lower data write lost while the pins are bus");

  upper_dir_wr_a: assert property (
    s_upper_dir_wr ##0 !i_hw_standby |=> s_q.dir_u == $past(i_wdata)
  ) else $error("upper direction write not stored");

endmodule
`default_nettype wire

// *** verif/dpg_pin_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module dpg_pin_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_pull,
  input  wire logic [7:0] i_ext,
  input  wire logic [7:0] i_ext_en,
  output logic      [7:0] o_pin
);
  // undriven, unpulled bits wander so a stale level never reads as valid
  logic [7:0] float_q = 8'h55;
  always_ff @(posedge i_clk) float_q <= ~float_q;
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      o_pin[b] = i_oe[b] ? i_out[b] : i_ext_en[b] ? i_ext[b] : i_pull[b] | float_q[b];
    end
  end
endmodule
`default_nettype wire

// *** verif/test_dpg_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_dpg_top;
  import dpg_pkg::*;
  logic        clk, rst_n, hw, sw, bdrv, wr, rd;
  logic [2:0]  mode;
  logic [7:0]  bwc, wdata, ext_u, ext_l, en_l, rdata, ou, oeu, ol, oel, pull, pin_u, pin_l;
  logic [15:0] addr, bwd, brd;
  int          n_errors, compares;

  dpg_top u_dpg_top (.i_sys_clk(clk), .i_rst_n(rst_n), .i_hw_standby(hw), .i_sw_standby(sw),
    .i_mode(mode), .i_bus_area_width_control(bwc), .i_bus_drive(bdrv), .i_bus_wdata(bwd),
    .o_bus_rdata(brd), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_upper_pin(pin_u), .o_upper_pin(ou), .o_upper_pin_oe(oeu), .i_lower_pin(pin_l),
    .o_lower_pin(ol), .o_lower_pin_oe(oel), .o_lower_pullup(pull));
  dpg_pin_model u_dpg_pin_model (.i_clk(clk), .i_out(ou), .i_oe(oeu), .i_pull(8'h00),
    .i_ext(ext_u), .i_ext_en(8'hff), .o_pin(pin_u));
  dpg_pin_model u_dpg_pin_model_l (.i_clk(clk), .i_out(ol), .i_oe(oel), .i_pull(pull),
    .i_ext(ext_l), .i_ext_en(en_l), .o_pin(pin_l));

  // ----------------------------------------
  // bus tasks and checking
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rd8(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk) begin addr <= a; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) chk(rdata, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin clk = 1'b0; forever #50 clk = ~clk; end
  initial begin #(2000 * 100); n_errors++; end_sim; end
  initial begin
    {rst_n, hw, sw, bdrv, wr, rd} = '0;
    {addr, wdata, bwd} = '0;
    mode = MODE_SINGLE; bwc = 8'hfe; ext_u = 8'h3c; ext_l = 8'h00; en_l = 8'hff;
    n_errors = 0; compares = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd8(UPPER_DIR_ADDR, WO_READ_VALUE);
    rd8(LOWER_DIR_ADDR, WO_READ_VALUE);
    rd8(LOWER_DATA_ADDR, REG_RESET);
    rd8(LOWER_PU_ADDR, REG_RESET);
    wr8(16'hffc8, 8'h77);
    rd8(16'hffc8, UNMAPPED_VALUE);
    rd8(UPPER_DATA_ADDR, 8'h3c);
    $display("test reset map done");
    wr8(UPPER_DIR_ADDR, 8'hf0);
    wr8(UPPER_DATA_ADDR, 8'ha5);
    cyc(2);
    chk(oeu, 8'hf0);
    chk(ou & 8'hf0, 8'ha0);
    rd8(UPPER_DATA_ADDR, 8'hac);
    @(posedge clk) sw <= 1'b1;
    cyc(3);
    chk(oeu, 8'hf0);
    rd8(UPPER_DATA_ADDR, 8'hac);
    @(posedge clk) begin sw <= 1'b0; en_l <= 8'h00; end
    $display("test upper gpio done");
    wr8(LOWER_DIR_ADDR, 8'h0f);
    wr8(LOWER_PU_ADDR, 8'hff);
    wr8(LOWER_DATA_ADDR, 8'h5a);
    cyc(3);
    chk(oel, 8'h0f);
    chk(pull, 8'hf0);
    rd8(LOWER_PU_ADDR, 8'hff);
    rd8(LOWER_DATA_ADDR, 8'hfa);
    $display("test lower gpio done");
    @(posedge clk) begin bwc <= ALL_BYTE_AREAS; bdrv <= 1'b1; bwd <= 16'h9966; end
    for (int m = 1; m <= 6; m++) begin
      @(posedge clk) mode <= m[2:0];
      cyc(2);
      chk(oeu, 8'hff);
      chk(ou, 8'h99);
      chk(oel, 8'h0f);
      chk(pull, 8'hf0);
    end
    @(posedge clk) bwc <= 8'hfe;
    wr8(LOWER_DATA_ADDR, 8'h11);
    cyc(2);
    chk(oel, 8'hff);
    chk(ol, 8'h66);
    chk(pull, 8'h00);
    @(posedge clk) bdrv <= 1'b0;
    cyc(5);
    chk(brd[15:8], 8'h3c);
    @(posedge clk) mode <= MODE_SINGLE;
    cyc(3);
    rd8(LOWER_DATA_ADDR, 8'hf1);
    $display("test bus modes done");
    @(posedge clk) hw <= 1'b1;
    cyc(2);
    @(posedge clk) hw <= 1'b0;
    cyc(1);
    chk(oeu, 8'h00);
    rd8(UPPER_DATA_ADDR, 8'h3c);
    rd8(LOWER_PU_ADDR, REG_RESET);
    $display("test hardware standby done");
    @(posedge clk) begin en_l <= 8'hff; ext_l <= 8'h69; end
    cyc(4);
    chk(brd[7:0], 8'h69);
    @(posedge clk) begin addr <= UPPER_DIR_ADDR; wdata <= 8'hff; wr <= 1'b1; end
    @(posedge clk) begin addr <= UPPER_DATA_ADDR; wdata <= 8'h5c; end
    @(posedge clk) begin wr <= 1'b0; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) chk(rdata, 8'h5c);
    cyc(1);
    chk(ou, 8'h5c);
    $display("test back to back done");
    @(posedge clk) rst_n <= 1'b0;
    cyc(1);
    chk(oeu, 8'h00);
    chk(ou, 8'h00);
    @(posedge clk) rst_n <= 1'b1;
    cyc(2);
    rd8(UPPER_DATA_ADDR, 8'h3c);
    $display("test reset again done");
    end_sim;
  end
endmodule
`default_nettype wire
